// File: design/eelc_pkg.sv
package eelc_pkg;

  // Operation
  // - Nineteen edge detector lines, each raising interrupt or event requests
  // - Each line selects rising, falling or both edges as its trigger
  // - Each line has its own mask, independent of all other lines
  // - Per-line pending bits record detected interrupt requests, readable by software
  // - Edges are caught asynchronously, so pulses shorter than a clock still count
  // - Sixteen lines come from pins, each selectable among up to 112 pins
  // - Supply monitor and alarm drive lines; any line can wake from stop

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_LINES  = 19;
  localparam int NUM_EXT    = 16;
  localparam int NUM_PINS   = 112;
  localparam int PSEL_W     = 7;
  localparam int PSEL_LANE  = 8;
  localparam int PSEL_PER   = 4;
  localparam int ADDR_W     = 8;

  // ****************************************
  // Internal line positions
  // ****************************************
  localparam int LINE_SUPPLY = 16;
  localparam int LINE_ALARM  = 17;
  localparam int LINE_AUX    = 18;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RISE_SEL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FALL_SEL  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PENDING   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STAT_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PIN_SEL0  = 8'h20;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [NUM_LINES-1:0] RST_LINES = 19'h0;
  localparam logic [PSEL_W-1:0]    RST_PSEL  = 7'h0;
  localparam logic [1:0]           HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic [1:0]           HRESP_OKAY = 2'h0;

  typedef enum logic {
    BUS_IDLE,
    BUS_DATA
  } eelc_bus_e;

endpackage

// File: design/eelc_edge_if.sv
`timescale 1ns/1ps
interface eelc_edge_if;
  import eelc_pkg::*;

  logic [NUM_LINES-1:0] rise_evt;
  logic [NUM_LINES-1:0] fall_evt;

  modport catcher (
    output rise_evt,
    output fall_evt
  );

  modport core (
    input  rise_evt,
    input  fall_evt
  );

endinterface

// File: design/eelc_edge_catch.sv
`timescale 1ns/1ps
module eelc_edge_catch #(
  parameter int N = eelc_pkg::NUM_LINES
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Raw lines
  input  wire logic [N-1:0] line_in,
  // Edge pulses
  eelc_edge_if.catcher      edges
);
  import eelc_pkg::*;

  logic [N-1:0] evt [2];

  assign edges.rise_evt = evt[0];
  assign edges.fall_evt = evt[1];

  // ****************************************
  // Asynchronous catch per line and polarity
  // ****************************************
  for (genvar i = 0; i < N; i++) begin : g_line
    for (genvar p = 0; p < 2; p++) begin : g_pol
      wire logic  edge_clk;
      logic       caught;
      logic [1:0] sync;
      logic       clr;

      assign edge_clk = (p == 0) ? line_in[i] : ~line_in[i];

      // Line edge clocks the flop, so any width is kept
      always_ff @(posedge edge_clk or posedge clr) begin
        if (clr) begin
          caught <= 1'b0;
        end else begin
          caught <= 1'b1;
        end
      end

      // Clear handshake; edges while caught is set merge with the one held, edges while clr is high are lost
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          sync <= 2'h0;
          clr  <= 1'b1;
        end else begin
          sync <= {sync[0], caught};
          clr  <= sync[1];
        end
      end

      assign evt[p][i] = sync[1] & ~clr;
    end
  end

endmodule

// File: design/eelc_top.sv
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module eelc_top #(
  parameter int N_PINS = eelc_pkg::NUM_PINS
) (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           sys_rst,
  // AHB-Lite slave
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic [1:0]                          hresp,
  output logic [31:0]                         hrdata,
  // Line sources
  input  wire logic [N_PINS-1:0]              gpio_pins,
  input  wire logic                           supply_voltage_monitor,
  input  wire logic                           rtc_alarm,
  input  wire logic                           aux_line,
  // Requests
  output logic [eelc_pkg::NUM_LINES-1:0]      line_irq,
  output logic [eelc_pkg::NUM_LINES-1:0]      line_evt,
  output logic                                wake_req,
  output logic                                irq
);
  import eelc_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic pick_pin(
    input logic [N_PINS-1:0] pins,
    input logic [PSEL_W-1:0] sel
  );
    logic r;
    r = 1'b0;
    for (int j = 0; j < N_PINS; j++) begin
      if (sel == PSEL_W'(j)) begin
        r = pins[j];
      end
    end
    return r;
  endfunction

  function automatic logic ofs_hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    return a == ofs;
  endfunction

  function automatic logic psel_hit(
    input logic [ADDR_W-1:0] a,
    input int                k
  );
    return a[3:2] == 2'(k / PSEL_PER);
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [NUM_LINES-1:0] irq_mask;
  logic [NUM_LINES-1:0] evt_mask;
  logic [NUM_LINES-1:0] rise_sel;
  logic [NUM_LINES-1:0] fall_sel;
  logic [NUM_LINES-1:0] pending;
  logic [NUM_LINES-1:0] status;
  logic [NUM_LINES-1:0] stat_mask;
  logic [PSEL_W-1:0]    pin_sel [NUM_EXT];

  eelc_bus_e            bus_state;
  logic [ADDR_W-1:0]    a_addr;
  logic                 a_write;

  // ****************************************
  // Line sources
  // ****************************************
  logic [NUM_LINES-1:0] line_src;

  // Changing a selector may glitch the line and fire a false edge;
  // software should mask the line while it re-routes it
  always_comb begin
    line_src = '0;
    for (int k = 0; k < NUM_EXT; k++) begin
      line_src[k] = pick_pin(gpio_pins, pin_sel[k]);
    end
    line_src[LINE_SUPPLY] = supply_voltage_monitor;
    line_src[LINE_ALARM]  = rtc_alarm;
    line_src[LINE_AUX]    = aux_line;
  end

  // ****************************************
  // Edge capture
  // ****************************************
  eelc_edge_if edges ();

  eelc_edge_catch #(
    .N (NUM_LINES)
  ) u_catch (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .line_in (line_src),
    .edges   (edges.catcher)
  );

  wire logic [NUM_LINES-1:0] line_hit;
  wire logic [NUM_LINES-1:0] irq_hit;
  wire logic [NUM_LINES-1:0] evt_hit;

  assign line_hit = (edges.rise_evt & rise_sel)
                  | (edges.fall_evt & fall_sel);
  assign irq_hit  = line_hit & irq_mask;
  assign evt_hit  = line_hit & evt_mask;

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic take;
  wire logic wr_en;
  wire logic rd_en;
  wire logic in_psel;

  // One wait state lets read data come from a flop
  assign take    = hsel & htrans[1] & hready & (bus_state == BUS_IDLE);
  assign wr_en   = (bus_state == BUS_DATA) & a_write;
  assign rd_en   = (bus_state == BUS_DATA) & ~a_write;
  assign in_psel = a_addr[ADDR_W-1:4] == OFS_PIN_SEL0[ADDR_W-1:4];

  wire logic wr_imr;
  wire logic wr_emr;
  wire logic wr_rise;
  wire logic wr_fall;
  wire logic wr_pend;
  wire logic wr_smask;
  wire logic rd_stat;

  assign wr_imr   = wr_en & ofs_hit(a_addr, OFS_IRQ_MASK);
  assign wr_emr   = wr_en & ofs_hit(a_addr, OFS_EVT_MASK);
  assign wr_rise  = wr_en & ofs_hit(a_addr, OFS_RISE_SEL);
  assign wr_fall  = wr_en & ofs_hit(a_addr, OFS_FALL_SEL);
  assign wr_pend  = wr_en & ofs_hit(a_addr, OFS_PENDING);
  assign wr_smask = wr_en & ofs_hit(a_addr, OFS_STAT_MASK);
  assign rd_stat  = rd_en & ofs_hit(a_addr, OFS_STATUS);

  // ****************************************
  // Read mux
  // ****************************************
  logic [31:0] psel_word;

  always_comb begin
    psel_word = 32'h0;
    for (int k = 0; k < NUM_EXT; k++) begin
      if (psel_hit(a_addr, k)) begin
        psel_word[(k % PSEL_PER)*PSEL_LANE +: PSEL_W] = pin_sel[k];
      end
    end
  end

  wire logic [31:0] rdata;

  assign rdata =
    ofs_hit(a_addr, OFS_IRQ_MASK)  ? 32'(irq_mask)  :
    ofs_hit(a_addr, OFS_EVT_MASK)  ? 32'(evt_mask)  :
    ofs_hit(a_addr, OFS_RISE_SEL)  ? 32'(rise_sel)  :
    ofs_hit(a_addr, OFS_FALL_SEL)  ? 32'(fall_sel)  :
    ofs_hit(a_addr, OFS_PENDING)   ? 32'(pending)   :
    ofs_hit(a_addr, OFS_STATUS)    ? 32'(status)    :
    ofs_hit(a_addr, OFS_STAT_MASK) ? 32'(stat_mask) :
    in_psel                        ? psel_word      :
                                     32'h0;

  // ****************************************
  // Sticky state
  // ****************************************
  wire logic [NUM_LINES-1:0] pend_clr;
  wire logic [NUM_LINES-1:0] next_pending;
  wire logic [NUM_LINES-1:0] next_status;

  // Write one clears pending, a read of STATUS clears status; a new request wins over the clear
  assign pend_clr     = wr_pend ? hwdata[NUM_LINES-1:0] : RST_LINES;
  assign next_pending = (pending & ~pend_clr) | irq_hit;
  assign next_status  = (rd_stat ? RST_LINES : status) | evt_hit;

  // ****************************************
  // Request decode
  // ****************************************
  wire logic [NUM_LINES-1:0] next_line_irq;
  wire logic                 next_wake_req;
  wire logic                 next_irq;

  // Mask writes reach the request outputs one edge after the write
  assign next_line_irq = next_pending & irq_mask;
  assign next_wake_req = |(evt_hit | next_line_irq);
  assign next_irq      = |(next_status & stat_mask);

  // ****************************************
  // Bus state machine
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_state <= BUS_IDLE;
      a_addr    <= OFS_IRQ_MASK;
      a_write   <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (take) begin
            a_addr    <= haddr[ADDR_W-1:0];
            a_write   <= hwrite;
            hreadyout <= 1'b0;
            bus_state <= BUS_DATA;
          end
        end
        BUS_DATA: begin
          hrdata    <= a_write ? 32'h0 : rdata;
          hreadyout <= 1'b1;
          bus_state <= BUS_IDLE;
        end
        default: begin
          hreadyout <= 1'b1;
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_mask  <= RST_LINES;
      evt_mask  <= RST_LINES;
      rise_sel  <= RST_LINES;
      fall_sel  <= RST_LINES;
      stat_mask <= RST_LINES;
    end else begin
      if (wr_imr) begin
        irq_mask <= hwdata[NUM_LINES-1:0];
      end
      if (wr_emr) begin
        evt_mask <= hwdata[NUM_LINES-1:0];
      end
      if (wr_rise) begin
        rise_sel <= hwdata[NUM_LINES-1:0];
      end
      if (wr_fall) begin
        fall_sel <= hwdata[NUM_LINES-1:0];
      end
      if (wr_smask) begin
        stat_mask <= hwdata[NUM_LINES-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int k = 0; k < NUM_EXT; k++) begin
      if (sys_rst) begin
        pin_sel[k] <= RST_PSEL;
      end else if (wr_en && in_psel && psel_hit(a_addr, k)) begin
        pin_sel[k] <= hwdata[(k % PSEL_PER)*PSEL_LANE +: PSEL_W];
      end
    end
  end

  // ****************************************
  // Pending, status and requests
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pending  <= RST_LINES;
      status   <= RST_LINES;
      line_irq <= RST_LINES;
      line_evt <= RST_LINES;
      wake_req <= 1'b0;
      irq      <= 1'b0;
    end else begin
      pending  <= next_pending;
      status   <= next_status;
      line_irq <= next_line_irq;
      line_evt <= evt_hit;
      wake_req <= next_wake_req;
      irq      <= next_irq;
    end
  end

endmodule

// File: sim/eelc_properties.sv
`timescale 1ns/1ps
module eelc_checker
  import eelc_pkg::*;
(
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  // Bus
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic [1:0]           hresp,
  input wire logic [31:0]          hrdata,
  // Requests
  input wire logic [NUM_LINES-1:0] line_irq,
  input wire logic [NUM_LINES-1:0] line_evt,
  input wire logic                 wake_req,
  input wire logic                 irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire take = hsel && htrans[1] && hready && hreadyout;
  wire unmapped = haddr[7:0] >= 8'h30;
  sequence s_take;
    take;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_one_wait: assert property (s_take |=> s_wait)
    else $error("transfer without one wait state");
  a_resp_okay: assert property (hresp == 2'h0)
    else $error("response not okay");
  a_write_zero: assert property (s_take ##0 hwrite |-> ##2 hrdata == 32'h0)
    else $error("read data not zero after write");
  a_unmapped_zero: assert property (s_take ##0 (!hwrite && unmapped) |->
    ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a transfer");
  a_evt_pulse: assert property (line_evt != 0 |=> (line_evt & $past(line_evt)) == 0)
    else $error("event request longer than one cycle");
  a_wake_follow: assert property (line_irq != 0 || line_evt != 0 |-> ##[0:1] wake_req)
    else $error("no wake request");
  a_pend_drop: assert property (($past(line_irq) & ~line_irq) != 0 |->
    $past(take) || $past(take, 2) || $past(take, 3))
    else $error("line request dropped without a bus write");
  a_irq_drop: assert property ($fell(irq) |->
    $past(take) || $past(take, 2) || $past(take, 3))
    else $error("interrupt dropped without a bus access");
endmodule

bind eelc_top eelc_checker eelc_checker_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .line_irq(line_irq), .line_evt(line_evt), .wake_req(wake_req), .irq(irq)
);

// File: sim/eelc_src_model.sv
`timescale 1ns/1ps
module eelc_src_model
  import eelc_pkg::*;
(
  // Commands
  input wire logic            kick,
  input wire logic [7:0]      sel,
  input wire logic            lvl,
  input wire logic            pulse,
  // Sources
  output logic [NUM_PINS-1:0] gpio_pins,
  output logic                supply_voltage_monitor,
  output logic                rtc_alarm,
  output logic                aux_line
);
  logic [NUM_PINS+2:0] src = '0;
  // Off the clock grid, so capture cannot lean on sampling
  always @(kick) begin
    #1;
    src[sel] = pulse ? ~src[sel] : lvl;
    if (pulse) begin
      #0.8;
      src[sel] = ~src[sel];
    end
  end
  assign gpio_pins              = src[NUM_PINS-1:0];
  assign supply_voltage_monitor = src[NUM_PINS];
  assign rtc_alarm              = src[NUM_PINS+1];
  assign aux_line               = src[NUM_PINS+2];
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  import eelc_pkg::*;
  logic                 clk_sys, sys_rst, hsel, hwrite, hreadyout, wake_req, irq;
  logic                 kick, lvl, pulse, sup, alm, aux;
  logic [31:0]          haddr, hwdata, hrdata, rd;
  logic [1:0]           htrans, hresp;
  logic [2:0]           hsize;
  logic [7:0]           sel;
  logic [NUM_PINS-1:0]  pins;
  logic [NUM_LINES-1:0] line_irq, line_evt, evt_seen;
  int                   n_mismatch = 0;
  int                   compares = 0;

  eelc_top eelc_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gpio_pins(pins),
    .supply_voltage_monitor(sup), .rtc_alarm(alm), .aux_line(aux), .line_irq(line_irq),
    .line_evt(line_evt), .wake_req(wake_req), .irq(irq));
  eelc_src_model eelc_src_model_i (.kick(kick), .sel(sel), .lvl(lvl), .pulse(pulse),
    .gpio_pins(pins), .supply_voltage_monitor(sup), .rtc_alarm(alm), .aux_line(aux));

  // Event requests last one cycle, so keep a sticky copy for the checks
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      evt_seen <= '0;
    end else begin
      evt_seen <= evt_seen | line_evt;
    end
  end

  // ******
  // Tasks
  // ******
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits are bounded; a stuck wait state ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(posedge clk_sys); k++; end while (!hreadyout && k < 40);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk_sys); k++; end while (!hreadyout && k < 40);
    rd = hrdata;
    if (k >= 40) begin
      n_mismatch++;
      results();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(hresp), 32'(HRESP_OKAY));
  endtask

  task automatic fire(input logic [7:0] s, input logic l, input logic p);
    sel <= s;
    lvl <= l;
    pulse <= p;
    kick <= ~kick;
    repeat (8) @(posedge clk_sys);
  endtask

  // ******
  // Run
  // ******
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    sys_rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = '0; kick = 1'b0; sel = 8'hff; lvl = 1'b0; pulse = 1'b0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    for (int i = 0; i <= 16; i++) rdchk(8'(i * 4), 32'h0);
    $display("reset and map done");
    bus(1'b1, OFS_PIN_SEL0, 32'h0000_6f05);
    rdchk(OFS_PIN_SEL0, 32'h0000_6f05);
    bus(1'b1, OFS_IRQ_MASK, 32'h0005_0003);
    bus(1'b1, OFS_RISE_SEL, 32'h0007_0001);
    bus(1'b1, OFS_FALL_SEL, 32'h0001_0002);
    bus(1'b1, OFS_EVT_MASK, 32'h0002_0000);
    bus(1'b1, OFS_STAT_MASK, 32'h0002_0000);
    fire(8'd5, 1'b1, 1'b0);
    fire(8'd111, 1'b1, 1'b0);
    rdchk(OFS_PENDING, 32'h1);
    fire(8'd111, 1'b0, 1'b0);
    rdchk(OFS_PENDING, 32'h3);
    chk(32'(line_irq), 32'h3);
    $display("edge select done");
    bus(1'b1, OFS_PENDING, 32'h0);
    rdchk(OFS_PENDING, 32'h3);
    bus(1'b1, OFS_PENDING, 32'h1);
    rdchk(OFS_PENDING, 32'h2);
    bus(1'b1, OFS_PENDING, 32'h2);
    rdchk(OFS_PENDING, 32'h0);
    chk(32'(line_irq), 32'h0);
    $display("clear done");
    fire(8'd112, 1'b0, 1'b1);
    rdchk(OFS_PENDING, 32'h0001_0000);
    chk(32'(wake_req), 32'h1);
    bus(1'b1, OFS_PENDING, 32'h0001_0000);
    fire(8'd114, 1'b0, 1'b1);
    rdchk(OFS_PENDING, 32'h0004_0000);
    bus(1'b1, OFS_PENDING, 32'h0004_0000);
    chk(32'(wake_req), 32'h0);
    $display("short pulse done");
    fire(8'd113, 1'b1, 1'b0);
    rdchk(OFS_PENDING, 32'h0);
    chk(32'(evt_seen), 32'h0002_0000);
    chk(32'(irq), 32'h1);
    bus(1'b1, OFS_STAT_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    bus(1'b1, OFS_STAT_MASK, 32'h0002_0000);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h1);
    rdchk(OFS_STATUS, 32'h0002_0000);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    rdchk(OFS_STATUS, 32'h0);
    $display("interrupt done");
    results();
  end
endmodule
